// File: test/reset_and_port_g_control_test.sv
`timescale 1ns/1ps
module reset_and_port_g_control_test;
  // ************************************************************
  // Signals
  // ************************************************************
  logic pclk = 1'b0;
  // Starts high so the first reset makes a real falling edge
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rc_osc_option = 1'b0;
  logic osc_clk;
  logic clk_ok;
  logic [7:0] pg_in;
  logic clk_slow = 1'b0;
  logic g7_level = 1'b0;
  rpg_pkg::rpg_pins_t pg_pins;
  rpg_pkg::rpg_pins_t pl_pins;
  rpg_pkg::rpg_pins_t pc_pins;
  logic oscillator_clock_output;
  logic fault_output_pin_o;
  logic fault_output_pin_oe;
  logic [7:0] pd_out;
  logic halt_mode;
  logic idle_mode;
  logic alt_serial_shift_clock;
  logic [7:0] converter_control_reg;
  logic [7:0] stack_pointer;
  logic [31:0] rdv;
  int fail_count = 0;
  int checked = 0;

  always #4 pclk = ~pclk;

  rpg_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_osc_option(rc_osc_option), .osc_clk(osc_clk), .clk_ok(clk_ok),
    .pg_in(pg_in), .pg_pins(pg_pins),
    .oscillator_clock_output(oscillator_clock_output),
    .fault_output_pin_o(fault_output_pin_o),
    .fault_output_pin_oe(fault_output_pin_oe), .pl_pins(pl_pins),
    .pc_pins(pc_pins), .pd_out(pd_out), .halt_mode(halt_mode),
    .idle_mode(idle_mode), .alt_serial_shift_clock(alt_serial_shift_clock),
    .converter_control_reg(converter_control_reg),
    .stack_pointer(stack_pointer));

  rpg_board board (.pclk(pclk), .rc_osc_option(rc_osc_option),
    .clk_slow(clk_slow), .g7_level(g7_level), .pg_pins(pg_pins),
    .osc_out(oscillator_clock_output), .osc_clk(osc_clk),
    .clk_ok(clk_ok), .pg_in(pg_in));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Master never assumes a latency; the bound only cuts a hang
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    check(rdv & m, e);
  endtask : rdchk

  // Reset held with the clock already stable
  task automatic do_reset();
    presetn <= 1'b0;
    cyc(6);
    check({24'h0, pd_out}, 32'hff);
    check({24'h0, stack_pointer}, 32'h6f);
    check({8'h0, pg_pins}, 32'h0);
    check({8'h0, pl_pins ^ pc_pins}, 32'h0);
    check({8'h0, pl_pins & pc_pins}, 32'h0);
    check({24'h0, converter_control_reg}, 32'h0);
    check({30'h0, halt_mode, idle_mode}, 32'h0);
    check({31'h0, fault_output_pin_oe}, 32'h0);
    presetn <= 1'b1;
    cyc(1);
  endtask : do_reset

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rdchk(rpg_pkg::ADDR_SUPV, 32'h7, 32'h7);
    rdchk(rpg_pkg::ADDR_CTRL_A, 32'hffffffff, 32'h0);
    rdchk(rpg_pkg::ADDR_CTRL_B, 32'hffffffff, 32'h0);
    rdchk(rpg_pkg::ADDR_CPU_PTRS, 32'hff00, 32'h6f00);
    rdchk(rpg_pkg::ADDR_PD_DATA, 32'hff, 32'hff);
    apb(rpg_pkg::ADDR_PD_DATA, 1'b1, 32'h5a);
    cyc(2);
    check({24'h0, pd_out}, 32'h5a);
    apb(rpg_pkg::ADDR_CPU_PTRS, 1'b1, 32'hff5b6e4c);
    cyc(1);
    check({24'h0, stack_pointer}, 32'h6e);
    rdchk(rpg_pkg::ADDR_CPU_PTRS, 32'hffffffff, 32'h005b6e4c);
    apb(8'hfc, 1'b1, 32'hffffffff);
    rdchk(8'hfc, 32'hffffffff, 32'h0);
    check({31'h0, pslverr}, 32'h0);
    $display("done: reset registers");
  endtask : t_regs

  task automatic t_ports();
    apb(rpg_pkg::ADDR_PL_CFG, 1'b1, 32'h0f);
    apb(rpg_pkg::ADDR_PC_DATA, 1'b1, 32'h33);
    cyc(2);
    check({8'h0, pl_pins}, 32'h000f00);
    check({8'h0, pc_pins}, 32'h000033);
    apb(rpg_pkg::ADDR_PG_CFG, 1'b1, 32'h4e);
    apb(rpg_pkg::ADDR_PG_DATA, 1'b1, 32'h68);
    cyc(3);
    check({31'h0, idle_mode}, 32'h1);
    rdchk(rpg_pkg::ADDR_PG_DATA, 32'hff, 32'h28);
    rdchk(rpg_pkg::ADDR_PG_CFG, 32'hff, 32'h4e);
    check({8'h0, pg_pins}, 32'h080c20);
    check({31'h0, alt_serial_shift_clock}, 32'h1);
    check({30'h0, fault_output_pin_o, fault_output_pin_oe}, 32'h0);
    rdchk(rpg_pkg::ADDR_PG_PIN, 32'h3d, 32'h28);
    apb(rpg_pkg::ADDR_PG_DATA, 1'b1, 32'h28);
    cyc(3);
    check({31'h0, idle_mode}, 32'h0);
    $display("done: port g modes");
  endtask : t_ports

  task automatic t_halt();
    rc_osc_option <= 1'b1;
    g7_level <= 1'b0;
    apb(rpg_pkg::ADDR_PG_DATA, 1'b1, 32'h80);
    cyc(3);
    check({31'h0, halt_mode}, 32'h1);
    g7_level <= 1'b1;
    cyc(4);
    check({31'h0, halt_mode}, 32'h0);
    rdchk(rpg_pkg::ADDR_STATUS, 32'h6, 32'h0);
    apb(rpg_pkg::ADDR_PG_CFG, 1'b1, 32'hce);
    g7_level <= 1'b0;
    apb(rpg_pkg::ADDR_PG_DATA, 1'b1, 32'h80);
    cyc(3);
    g7_level <= 1'b1;
    cyc(4);
    rdchk(rpg_pkg::ADDR_STATUS, 32'h6, 32'h6);
    cyc(300);
    rdchk(rpg_pkg::ADDR_STATUS, 32'h6, 32'h0);
    $display("done: halt and restart delay");
  endtask : t_halt

  task automatic t_osc();
    int ones;
    ones = 0;
    rc_osc_option <= 1'b1;
    cyc(2);
    repeat (8) begin
      @(posedge pclk);
      ones += int'(oscillator_clock_output === 1'b1);
    end
    check(32'(ones), 32'h0);
    rc_osc_option <= 1'b0;
    cyc(2);
    ones = 0;
    repeat (8) begin
      @(posedge pclk);
      ones += int'(oscillator_clock_output === 1'b1);
    end
    check({31'h0, ones > 0 && ones < 8}, 32'h1);
    $display("done: clock output");
  endtask : t_osc

  task automatic t_fault();
    int n;
    clk_slow <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (fault_output_pin_oe !== 1'b1 && n < 10);
    check({30'h0, fault_output_pin_oe, fault_output_pin_o}, 32'h2);
    if (fault_output_pin_oe !== 1'b1) wrap_up();
    clk_slow <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (fault_output_pin_oe !== 1'b0 && n < 40);
    // Detector lag and output register add up to two edges
    check({31'h0, n >= 16 && n <= 34}, 32'h1);
    if (fault_output_pin_oe !== 1'b0) wrap_up();
    $display("done: clock fault output");
  endtask : t_fault

  task automatic t_rerun();
    apb(rpg_pkg::ADDR_CTRL_B, 1'b1, 32'ha5000000);
    cyc(2);
    check({24'h0, converter_control_reg}, 32'ha5);
    do_reset();
    rdchk(rpg_pkg::ADDR_CTRL_B, 32'hffffffff, 32'h0);
    rdchk(rpg_pkg::ADDR_PG_CFG, 32'hff, 32'h0);
    rdchk(rpg_pkg::ADDR_SUPV, 32'h7, 32'h7);
    $display("done: reset in mid-run");
  endtask : t_rerun

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    do_reset();
    t_regs();
    t_ports();
    t_halt();
    t_osc();
    t_fault();
    t_rerun();
    wrap_up();
  end
endmodule : reset_and_port_g_control_test

// File: test/rpg_board.sv
`timescale 1ns/1ps
module rpg_board (
  // Clock and strap
  input wire logic pclk,
  input wire logic rc_osc_option,
  // Bench controls
  input wire logic clk_slow,
  input wire logic g7_level,
  // Device pins
  input wire rpg_pkg::rpg_pins_t pg_pins,
  input wire logic osc_out,
  output logic osc_clk,
  output logic clk_ok,
  output logic [7:0] pg_in
);
  // ************************************************************
  // Oscillator and frequency detector
  // ************************************************************
  initial osc_clk = 1'b0;
  initial clk_ok = 1'b1;
  always @(posedge pclk) osc_clk <= ~osc_clk;
  // Detector reports one edge late, as a real analog monitor would
  always @(posedge pclk) clk_ok <= ~clk_slow;

  // ************************************************************
  // Pin resolution
  // ************************************************************
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pg_pins.oe[i]) pg_in[i] = pg_pins.out[i];
      else pg_in[i] = pg_pins.pu[i];
    end
    // G7 is an input only in the R/C option
    pg_in[7] = rc_osc_option ? g7_level : osc_out;
  end
endmodule : rpg_board

// File: verilog/rpg_ctrl.sv
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module rpg_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps and status inputs
  input wire logic rc_osc_option,
  input wire logic osc_clk,
  input wire logic clk_ok,
  input wire logic [7:0] pg_in,
  // Port G pins
  output rpg_pkg::rpg_pins_t pg_pins,
  output logic oscillator_clock_output,
  output logic fault_output_pin_o,
  output logic fault_output_pin_oe,
  // Port L, C and D pins
  output rpg_pkg::rpg_pins_t pl_pins,
  output rpg_pkg::rpg_pins_t pc_pins,
  output logic [7:0] pd_out,
  // Mode and control outputs
  output logic halt_mode,
  output logic idle_mode,
  output logic alt_serial_shift_clock,
  output logic [7:0] converter_control_reg,
  output logic [7:0] stack_pointer
);

  // ************************************************************
  // Registers
  // ************************************************************
  rpg_pkg::rpg_port_t pg_r, pl_r, pc_r;
  rpg_pkg::rpg_pins_t pg_nxt, pl_nxt, pc_nxt;
  rpg_pkg::rpg_pmode_t pmode_r;
  logic [7:0] pd_r;
  logic [1:0] win_r;
  logic mon_r;
  logic fault_r;
  logic [5:0] ok_cnt_r;
  logic [16:0] wdog_cnt_r;
  logic [11:0] dly_cnt_r;
  logic [7:0] xptr_r, bptr_r, psw_r;
  logic [7:0] timer_serial_control_r, interrupt_control_r;
  logic [7:0] second_timer_control_r, wakeup_enable_r;
  logic [7:0] wakeup_edge_r, wakeup_pending_r;
  logic [14:0] pc_r_q;
  logic g7_d_r;
  logic wr, rd, wake;
  logic [31:0] rdata;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  // R/C option: G7 rising edge leaves HALT
  assign wake = rc_osc_option & pg_in[7] & ~g7_d_r;

  // ************************************************************
  // Port data and configuration registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_r <= '0;
      pl_r <= '0;
      pc_r <= '0;
      pd_r <= rpg_pkg::PD_RESET;
    end else if (wr) begin
      case (paddr)
        // Per-bit fields, each G I/O bit stands alone
        rpg_pkg::ADDR_PG_DATA: pg_r.data <= pwdata[7:0];
        rpg_pkg::ADDR_PG_CFG: pg_r.cfg <= pwdata[7:0];
        rpg_pkg::ADDR_PL_DATA: pl_r.data <= pwdata[7:0];
        rpg_pkg::ADDR_PL_CFG: pl_r.cfg <= pwdata[7:0];
        rpg_pkg::ADDR_PC_DATA: pc_r.data <= pwdata[7:0];
        rpg_pkg::ADDR_PC_CFG: pc_r.cfg <= pwdata[7:0];
        rpg_pkg::ADDR_PD_DATA: pd_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // CPU-side control registers set by reset: stack pointer to 6F, the rest cleared
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r_q <= rpg_pkg::PC_RESET;
      psw_r <= '0;
      timer_serial_control_r <= '0;
      interrupt_control_r <= '0;
      second_timer_control_r <= '0;
      wakeup_enable_r <= '0;
      wakeup_edge_r <= '0;
      wakeup_pending_r <= '0;
      converter_control_reg <= '0;
      stack_pointer <= rpg_pkg::SP_RESET;
      xptr_r <= '0;
      bptr_r <= '0;
    end else if (wr) begin
      case (paddr)
        rpg_pkg::ADDR_CTRL_A: begin
          psw_r <= pwdata[7:0];
          timer_serial_control_r <= pwdata[15:8];
          interrupt_control_r <= pwdata[23:16];
          second_timer_control_r <= pwdata[31:24];
        end
        rpg_pkg::ADDR_CTRL_B: begin
          wakeup_enable_r <= pwdata[7:0];
          wakeup_edge_r <= pwdata[15:8];
          wakeup_pending_r <= pwdata[23:16];
          converter_control_reg <= pwdata[31:24];
        end
        rpg_pkg::ADDR_CPU_PTRS: begin
          // Byte lanes follow pointer data addresses 0FC..0FF
          xptr_r <= pwdata[7:0];
          stack_pointer <= pwdata[15:8];
          bptr_r <= pwdata[23:16];
        end
        rpg_pkg::ADDR_PC_RST: pc_r_q <= pwdata[14:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Low-power mode control
  // ************************************************************
  // G7 sampled once a cycle; pin inputs are synchronous already
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g7_d_r <= 1'b0;
    end else begin
      g7_d_r <= pg_in[7];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmode_r <= rpg_pkg::PM_RUN;
      dly_cnt_r <= '0;
    end else begin
      case (pmode_r)
        rpg_pkg::PM_RUN: begin
          if (wr && paddr == rpg_pkg::ADDR_PG_DATA) begin
            if (pwdata[rpg_pkg::BIT_HALT]) begin
              pmode_r <= rpg_pkg::PM_HALT;
            end else if (pwdata[rpg_pkg::BIT_IDLE]) begin
              pmode_r <= rpg_pkg::PM_IDLE;
            end
          end
        end
        rpg_pkg::PM_IDLE: begin
          // Any later bus write ends IDLE
          if (wr) begin
            pmode_r <= rpg_pkg::PM_RUN;
          end
        end
        rpg_pkg::PM_HALT: begin
          if (wake) begin
            if (pg_r.cfg[rpg_pkg::BIT_RESTART_DLY]) begin
              pmode_r <= rpg_pkg::PM_WAKE;
              dly_cnt_r <= 12'(rpg_pkg::RESTART_DELAY_CYC - 1);
            end else begin
              pmode_r <= rpg_pkg::PM_RUN;
            end
          end
        end
        rpg_pkg::PM_WAKE: begin
          if (dly_cnt_r == '0) begin
            pmode_r <= rpg_pkg::PM_RUN;
          end else begin
            dly_cnt_r <= dly_cnt_r - 12'h001;
          end
        end
        default: pmode_r <= rpg_pkg::PM_RUN;
      endcase
    end
  end

  // ************************************************************
  // Supervisory timer and clock monitor
  // ************************************************************
  // Counters idle in reset, so neither detector can fire then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r <= rpg_pkg::WIN_RESET;
      mon_r <= 1'b1;
      wdog_cnt_r <= '0;
      ok_cnt_r <= '0;
      fault_r <= 1'b0;
    end else begin
      if (wr && paddr == rpg_pkg::ADDR_SUPV) begin
        win_r <= pwdata[1:0];
        mon_r <= pwdata[2];
        wdog_cnt_r <= '0;
      end else if (wdog_cnt_r < 17'(rpg_pkg::WIN_MAX_CYC)) begin
        wdog_cnt_r <= wdog_cnt_r + 17'h00001;
      end
      // Slow clock at or after reset: drive low, hold 16 cycles
      if (mon_r && !clk_ok) begin
        fault_r <= 1'b1;
        ok_cnt_r <= '0;
      end else if (fault_r) begin
        if (ok_cnt_r == 6'(rpg_pkg::FAULT_HOLD_MIN - 1)) begin
          fault_r <= 1'b0;
        end else begin
          ok_cnt_r <= ok_cnt_r + 6'h01;
        end
      end else if (wdog_cnt_r == 17'(rpg_pkg::WIN_MAX_CYC - 1)) begin
        fault_r <= 1'b1;
        ok_cnt_r <= '0;
      end
    end
  end

  // ************************************************************
  // Registered pin outputs
  // ************************************************************
  rpg_pin_mode u_pg (.regs(pg_r), .pins(pg_nxt));
  rpg_pin_mode u_pl (.regs(pl_r), .pins(pl_nxt));
  rpg_pin_mode u_pc (.regs(pc_r), .pins(pc_nxt));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_pins <= '0;
      pl_pins <= '0;
      pc_pins <= '0;
      pd_out <= rpg_pkg::PD_RESET;
      oscillator_clock_output <= 1'b0;
      fault_output_pin_o <= 1'b0;
      fault_output_pin_oe <= 1'b0;
      halt_mode <= 1'b0;
      idle_mode <= 1'b0;
      alt_serial_shift_clock <= 1'b0;
    end else begin
      // Only G0 and G2..G5 reach general port logic
      pg_pins.out <= pg_nxt.out & rpg_pkg::PG_IO_MASK;
      pg_pins.oe <= pg_nxt.oe & rpg_pkg::PG_IO_MASK;
      pg_pins.pu <= pg_nxt.pu & rpg_pkg::PG_IO_MASK;
      pl_pins <= pl_nxt;
      pc_pins <= pc_nxt;
      pd_out <= pd_r;
      oscillator_clock_output <= ~rc_osc_option & osc_clk;
      fault_output_pin_o <= 1'b0;
      fault_output_pin_oe <= fault_r;
      halt_mode <= pmode_r == rpg_pkg::PM_HALT ||
                   pmode_r == rpg_pkg::PM_WAKE;
      idle_mode <= pmode_r == rpg_pkg::PM_IDLE;
      alt_serial_shift_clock <= pg_r.cfg[rpg_pkg::BIT_ALT_SHIFT];
    end
  end

  // ************************************************************
  // APB read path, zero wait states
  // ************************************************************
  always_comb begin
    rdata = '0;
    case (paddr)
      // Special G6/G7 data bits never read back
      rpg_pkg::ADDR_PG_DATA:
        rdata = {24'h0, pg_r.data & rpg_pkg::PG_RD_MASK};
      rpg_pkg::ADDR_PG_CFG: rdata = {24'h0, pg_r.cfg};
      rpg_pkg::ADDR_PG_PIN: rdata = {24'h0, pg_in};
      rpg_pkg::ADDR_PL_DATA: rdata = {24'h0, pl_r.data};
      rpg_pkg::ADDR_PL_CFG: rdata = {24'h0, pl_r.cfg};
      rpg_pkg::ADDR_PC_DATA: rdata = {24'h0, pc_r.data};
      rpg_pkg::ADDR_PC_CFG: rdata = {24'h0, pc_r.cfg};
      rpg_pkg::ADDR_PD_DATA: rdata = {24'h0, pd_r};
      rpg_pkg::ADDR_SUPV: rdata = {29'h0, mon_r, win_r};
      rpg_pkg::ADDR_STATUS: rdata = {28'h0, fault_r, pmode_r, clk_ok};
      // Reserved byte 0FF reads zero
      rpg_pkg::ADDR_CPU_PTRS:
        rdata = {8'h0, bptr_r, stack_pointer, xptr_r};
      rpg_pkg::ADDR_CTRL_A: rdata = {second_timer_control_r,
        interrupt_control_r, timer_serial_control_r, psw_r};
      rpg_pkg::ADDR_CTRL_B: rdata = {converter_control_reg,
        wakeup_pending_r, wakeup_edge_r, wakeup_enable_r};
      rpg_pkg::ADDR_PC_RST: rdata = {17'h0, pc_r_q};
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (rd) begin
        prdata <= rdata;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_halt_entry: assert property (@(posedge pclk)
    disable iff (!presetn) wr && paddr == rpg_pkg::ADDR_PG_DATA &&
    pwdata[7] && pmode_r == rpg_pkg::PM_RUN |=> pmode_r == rpg_pkg::PM_HALT)
    else $error("halt not entered");
  a_idle_entry: assert property (@(posedge pclk)
    disable iff (!presetn) wr && paddr == rpg_pkg::ADDR_PG_DATA &&
    !pwdata[7] && pwdata[6] && pmode_r == rpg_pkg::PM_RUN |=> ##1 idle_mode)
    else $error("idle not entered");
  a_g67_read_zero: assert property (@(posedge pclk)
    disable iff (!presetn) rd && paddr == rpg_pkg::ADDR_PG_DATA |=>
    prdata[7:6] == 2'b00) else $error("G6/G7 data read nonzero");
  a_g1_not_io: assert property (@(posedge pclk)
    disable iff (!presetn) !pg_pins.oe[1] && !pg_pins.out[1] &&
    !fault_output_pin_o) else $error("G1 used as port");
  a_alt_phase: assert property (@(posedge pclk)
    disable iff (!presetn) ##1 alt_serial_shift_clock == $past(pg_r.cfg[6]))
    else $error("shift phase mismatch");
  sequence s_slow_clk;
    mon_r && !clk_ok;
  endsequence
  a_fault_low: assert property (@(posedge pclk)
    disable iff (!presetn) s_slow_clk |=> ##1 fault_output_pin_oe)
    else $error("fault pin not driven");
  a_fault_hold: assert property (@(posedge pclk)
    disable iff (!presetn) s_slow_clk ##1 (clk_ok [*8]) |-> fault_r)
    else $error("fault released early");
  a_fault_rel: assert property (@(posedge pclk)
    disable iff (!presetn) $fell(fault_r) |-> ##[1:2] !fault_output_pin_oe)
    else $error("fault not released");
  a_g7_wake: assert property (@(posedge pclk)
    disable iff (!presetn) pmode_r == rpg_pkg::PM_HALT && wake &&
    !pg_r.cfg[7] |=> pmode_r == rpg_pkg::PM_RUN)
    else $error("G7 wake failed");
  a_wake_delay: assert property (@(posedge pclk)
    disable iff (!presetn) pmode_r == rpg_pkg::PM_HALT && wake &&
    pg_r.cfg[7] |=> pmode_r == rpg_pkg::PM_WAKE [*8])
    else $error("restart delay skipped");
  a_reset_vals: assert property (@(posedge pclk)
    !presetn |-> stack_pointer == rpg_pkg::SP_RESET && pd_out == 8'hff &&
    win_r == 2'h3 && mon_r && converter_control_reg == 8'h00)
    else $error("reset values wrong");

endmodule : rpg_ctrl

// File: verilog/rpg_pin_mode.sv
`timescale 1ns/1ps
module rpg_pin_mode (
  // Register pair
  input wire rpg_pkg::rpg_port_t regs,
  // Pin controls
  output rpg_pkg::rpg_pins_t pins
);

  // ************************************************************
  // Per-bit pin mode decode
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // cfg:data 00 hi-z, 01 pull-up, 10 drive low, 11 drive high
      assign pins.oe[i] = regs.cfg[i];
      assign pins.out[i] = regs.cfg[i] & regs.data[i];
      assign pins.pu[i] = ~regs.cfg[i] & regs.data[i];
    end
  endgenerate

endmodule : rpg_pin_mode

// File: verilog/rpg_pkg.sv
package rpg_pkg;

  // ************************************************************
  // Register map (byte addresses on the APB bus)
  // ************************************************************
  localparam logic [7:0] ADDR_PG_DATA = 8'h00;
  localparam logic [7:0] ADDR_PG_CFG = 8'h04;
  localparam logic [7:0] ADDR_PG_PIN = 8'h08;
  localparam logic [7:0] ADDR_PL_DATA = 8'h0c;
  localparam logic [7:0] ADDR_PL_CFG = 8'h10;
  localparam logic [7:0] ADDR_PC_DATA = 8'h14;
  localparam logic [7:0] ADDR_PC_CFG = 8'h18;
  localparam logic [7:0] ADDR_PD_DATA = 8'h1c;
  localparam logic [7:0] ADDR_SUPV = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_CPU_PTRS = 8'h28;
  localparam logic [7:0] ADDR_CTRL_A = 8'h2c;
  localparam logic [7:0] ADDR_CTRL_B = 8'h30;
  localparam logic [7:0] ADDR_PC_RST = 8'h34;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int BIT_HALT = 7;
  localparam int BIT_IDLE = 6;
  localparam int BIT_ALT_SHIFT = 6;
  localparam int BIT_RESTART_DLY = 7;
  localparam int BIT_FAULT = 1;
  localparam logic [7:0] PG_IO_MASK = 8'h3d;
  localparam logic [7:0] PG_RD_MASK = 8'h3f;
  localparam logic [7:0] SP_RESET = 8'h6f;
  localparam logic [7:0] XPTR_ADDR = 8'hfc;
  localparam logic [7:0] SPTR_ADDR = 8'hfd;
  localparam logic [7:0] BPTR_ADDR = 8'hfe;
  localparam logic [7:0] RSVD_ADDR = 8'hff;
  localparam logic [7:0] PD_RESET = 8'hff;
  localparam logic [1:0] WIN_RESET = 2'h3;
  localparam logic [14:0] PC_RESET = 15'h0000;

  // ************************************************************
  // Timing (instruction-cycle clock, 8 ns)
  // ************************************************************
  localparam int CLK_NS = 8;
  localparam int WIN_MAX_CYC = 65536;
  localparam int FAULT_HOLD_MIN = 16;
  localparam int FAULT_HOLD_MAX = 32;
  localparam int RESTART_DELAY_NS = 2048;
  localparam int RESTART_DELAY_CYC = (RESTART_DELAY_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_IDLE,
    PM_HALT,
    PM_WAKE
  } rpg_pmode_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] cfg;
  } rpg_port_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } rpg_pins_t;

endpackage : rpg_pkg
